// ===== cdt_data_transfer_decode.sv
`include "cdt_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cdt_data_transfer_decode (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire cdt_pkg::cdt_instr_t instr,
  output logic instr_ready,
  output cdt_pkg::cdt_mem_req_t mem_o,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic flags_load,
  input wire cdt_pkg::cdt_flags_t flags_in,
  input wire logic [2:0] rd_sel,
  output logic [15:0] rd_data,
  output cdt_pkg::cdt_flags_t flags_o,
  output cdt_pkg::cdt_status_t status_o
);
  import cdt_pkg::*;

  // ==========================================================
  // helpers

  function automatic cdt_group_t type_group(input logic [5:0] t);
    if (t == `CDT_T_MOVE) return CDT_G_XFER;
    else if (t < `CDT_T_LOGIC_LO) return CDT_G_ARITH;
    else if (t < `CDT_T_SHIFT_LO) return CDT_G_LOGIC;
    else if (t < `CDT_T_BIT_LO) return CDT_G_SHIFT;
    else if (t < `CDT_T_BRANCH_LO) return CDT_G_BIT;
    else if (t < `CDT_T_SYS_LO) return CDT_G_BRANCH;
    else if (t < `CDT_T_BLOCK) return CDT_G_SYS;
    else return CDT_G_BLOCK;
  endfunction

  function automatic logic [15:0] read_op(input logic [15:0] r, input logic word,
                                          input logic lo);
    if (word) return r;
    else if (lo) return {`CDT_BYTE_ZX, r[7:0]};
    else return {`CDT_BYTE_ZX, r[15:8]};
  endfunction

  function automatic logic [15:0] write_op(input logic [15:0] r, input logic word,
                                           input logic lo, input logic [15:0] v);
    if (word) return v;
    else if (lo) return {r[15:8], v[7:0]};
    else return {v[7:0], r[7:0]};
  endfunction

  function automatic cdt_flags_t move_flags(input cdt_flags_t f, input logic word,
                                            input logic [15:0] v);
    cdt_flags_t r;
    r = f;
    r.n = word ? v[`CDT_WORD_MSB] : v[`CDT_BYTE_MSB];
    r.z = word ? (v == 16'h0000) : (v[7:0] == 8'h00);
    r.v = 1'b0;
    return r;
  endfunction

  function automatic logic [15:0] step_of(input logic word);
    return word ? `CDT_STEP_WORD : `CDT_STEP_BYTE;
  endfunction

  function automatic logic cond_true(input logic [3:0] c, input cdt_flags_t f);
    case (c)
      `CDT_C_ALWAYS: return 1'b1;
      `CDT_C_NEVER: return 1'b0;
      `CDT_C_CC: return !f.c;
      `CDT_C_CS: return f.c;
      `CDT_C_NE: return !f.z;
      `CDT_C_EQ: return f.z;
      `CDT_C_VC: return !f.v;
      `CDT_C_VS: return f.v;
      `CDT_C_PL: return !f.n;
      `CDT_C_MI: return f.n;
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // state

  cdt_state_t q;
  cdt_state_t d;

  logic [15:0] base_r;
  logic [15:0] ea;
  logic [15:0] val;
  logic [15:0] step;
  logic bad_form;

  always_comb begin
    d = q;
    base_r = 16'h0000;
    ea = 16'h0000;
    val = 16'h0000;
    step = 16'h0000;
    bad_form = 1'b0;
    d.status.done = 1'b0;
    d.status.branch_taken = 1'b0;
    d.rd_data = q.gpr[rd_sel];
    // outside flag updates yield to a move setting flags in the same cycle (register moves and loads as they finish, stores at issue)
    if (flags_load) begin
      d.flags = flags_in;
    end
    case (q.fsm)
      CDT_S_IDLE: begin
        if (instr.valid) begin
          d.pend = instr;
          d.status.group = type_group(instr.op_type);
          d.status.illegal = 1'b0;
          base_r = q.gpr[instr.rm];
          step = step_of(instr.word);
          // stack store and load have no code of their own; they arrive as plain moves
          bad_form = (instr.word && instr.mode == CDT_M_ABS8)
                     || (!instr.word && instr.rm == `CDT_STACK_PTR_IDX
                         && (instr.mode == CDT_M_PRE_DEC
                             || instr.mode == CDT_M_POST_INC))
                     || (instr.to_mem && (instr.mode == CDT_M_REG
                                          || instr.mode == CDT_M_IMM));
          case (instr.mode)
            CDT_M_IND: ea = base_r;
            CDT_M_POST_INC: ea = base_r;
            CDT_M_DISP16: ea = 16'(base_r + instr.ext);
            CDT_M_ABS16: ea = instr.ext;
            CDT_M_ABS8: ea = {`CDT_AA8_HI, instr.ext[7:0]};
            CDT_M_PRE_DEC: ea = 16'(base_r - step);
            default: ea = 16'h0000;
          endcase
          if (instr.word) begin
            ea[0] = 1'b0;
          end
          if (instr.op_type >= `CDT_NUM_TYPES) begin
            d.status.illegal = 1'b1;
            d.status.done = 1'b1;
          end else if (instr.op_type == `CDT_T_MOVE) begin
            if (bad_form) begin
              d.status.illegal = 1'b1;
              d.status.done = 1'b1;
            end else if (instr.mode == CDT_M_REG || instr.mode == CDT_M_IMM) begin
              if (instr.mode == CDT_M_REG) begin
                val = read_op(base_r, instr.word, instr.rm_lo);
              end else begin
                val = instr.word ? instr.ext : {`CDT_BYTE_ZX, instr.ext[7:0]};
              end
              d.gpr[instr.rn] = write_op(q.gpr[instr.rn], instr.word, instr.rn_lo, val);
              d.flags = move_flags(d.flags, instr.word, val);
              d.status.done = 1'b1;
            end else begin
              if (instr.mode == CDT_M_PRE_DEC) begin
                // register keeps the exact decremented value; only the bus address is forced even
                d.gpr[instr.rm] = 16'(base_r - step);
              end
              val = read_op(q.gpr[instr.rn], instr.word, instr.rn_lo);
              d.mem.req = 1'b1;
              d.mem.we = instr.to_mem;
              d.mem.word = instr.word;
              d.mem.addr = ea;
              d.mem.wdata = val;
              if (instr.to_mem) begin
                d.flags = move_flags(d.flags, instr.word, val);
              end
              d.ready = 1'b0;
              d.fsm = CDT_S_MEM;
            end
          end else if (instr.op_type == `CDT_T_BCC) begin
            // one type, many conditions
            d.status.branch_taken = cond_true(instr.cond, q.flags);
            d.status.done = 1'b1;
          end else begin
            // other groups only classified here; their datapath lives elsewhere
            d.status.done = 1'b1;
          end
        end
      end
      CDT_S_MEM: begin
        if (mem_ack) begin
          step = step_of(q.pend.word);
          d.mem.req = 1'b0;
          if (q.pend.mode == CDT_M_POST_INC) begin
            d.gpr[q.pend.rm] = 16'(q.gpr[q.pend.rm] + step);
          end
          // loaded value wins over the increment when both hit one register
          if (!q.mem.we) begin
            val = q.pend.word ? mem_rdata : {`CDT_BYTE_ZX, mem_rdata[7:0]};
            d.gpr[q.pend.rn] = write_op(q.gpr[q.pend.rn], q.pend.word, q.pend.rn_lo, val);
            d.flags = move_flags(d.flags, q.pend.word, val);
          end
          d.status.done = 1'b1;
          d.ready = 1'b1;
          d.fsm = CDT_S_IDLE;
        end
      end
      default: begin
        d.fsm = CDT_S_IDLE;
        d.ready = 1'b1;
        d.mem.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.fsm <= CDT_S_IDLE;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs straight from the state register

  assign instr_ready = q.ready;
  assign mem_o = q.mem;
  assign rd_data = q.rd_data;
  assign flags_o = q.flags;
  assign status_o = q.status;

endmodule

`default_nettype wire

// ===== cdt_consts.svh
`ifndef CDT_CONSTS_SVH
`define CDT_CONSTS_SVH

// ==========================================================
// instruction repertoire and type index layout
`define CDT_NUM_TYPES 6'h37
`define CDT_T_MOVE 6'h00
`define CDT_T_ARITH_LO 6'h01
`define CDT_T_LOGIC_LO 6'h0F
`define CDT_T_SHIFT_LO 6'h13
`define CDT_T_BIT_LO 6'h1B
`define CDT_T_BRANCH_LO 6'h29
`define CDT_T_BCC 6'h29
`define CDT_T_SYS_LO 6'h2E
`define CDT_T_BLOCK 6'h36

// ==========================================================
// addressing constants
`define CDT_STACK_PTR_IDX 3'h7
`define CDT_AA8_HI 8'hFF
`define CDT_STEP_BYTE 16'h0001
`define CDT_STEP_WORD 16'h0002
`define CDT_BYTE_ZX 8'h00
`define CDT_WORD_MSB 15
`define CDT_BYTE_MSB 7

// ==========================================================
// branch condition codes
`define CDT_C_ALWAYS 4'h0
`define CDT_C_NEVER 4'h1
`define CDT_C_CC 4'h2
`define CDT_C_CS 4'h3
`define CDT_C_NE 4'h4
`define CDT_C_EQ 4'h5
`define CDT_C_VC 4'h6
`define CDT_C_VS 4'h7
`define CDT_C_PL 4'h8
`define CDT_C_MI 4'h9

`endif

// ===== cdt_pkg.sv
package cdt_pkg;

  typedef enum logic [2:0] {
    CDT_M_REG = 3'h0,
    CDT_M_IND = 3'h1,
    CDT_M_DISP16 = 3'h2,
    CDT_M_ABS16 = 3'h3,
    CDT_M_ABS8 = 3'h4,
    CDT_M_IMM = 3'h5,
    CDT_M_PRE_DEC = 3'h6,
    CDT_M_POST_INC = 3'h7
  } cdt_mode_t;

  typedef enum logic [2:0] {
    CDT_G_XFER = 3'h0,
    CDT_G_ARITH = 3'h1,
    CDT_G_LOGIC = 3'h2,
    CDT_G_SHIFT = 3'h3,
    CDT_G_BIT = 3'h4,
    CDT_G_BRANCH = 3'h5,
    CDT_G_SYS = 3'h6,
    CDT_G_BLOCK = 3'h7
  } cdt_group_t;

  typedef enum logic [1:0] {
    CDT_S_IDLE = 2'b01,
    CDT_S_MEM = 2'b10
  } cdt_fsm_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cdt_flags_t;

  typedef struct packed {
    logic valid;
    logic [5:0] op_type;
    cdt_mode_t mode;
    logic word;
    logic to_mem;
    logic [2:0] rn;
    logic rn_lo;
    logic [2:0] rm;
    logic rm_lo;
    logic [15:0] ext;
    logic [3:0] cond;
  } cdt_instr_t;

  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cdt_mem_req_t;

  typedef struct packed {
    cdt_group_t group;
    logic done;
    logic illegal;
    logic branch_taken;
  } cdt_status_t;

  typedef struct packed {
    cdt_fsm_t fsm;
    logic ready;
    logic [7:0][15:0] gpr;
    cdt_flags_t flags;
    cdt_mem_req_t mem;
    cdt_status_t status;
    cdt_instr_t pend;
    logic [15:0] rd_data;
  } cdt_state_t;

endpackage

// ===== cdt_dtd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cdt_dtd_assertions (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire cdt_pkg::cdt_instr_t instr,
  input wire logic instr_ready,
  input wire cdt_pkg::cdt_mem_req_t mem_o,
  input wire logic mem_ack,
  input wire logic flags_load,
  input wire cdt_pkg::cdt_flags_t flags_in,
  input wire cdt_pkg::cdt_flags_t flags_o,
  input wire cdt_pkg::cdt_status_t status_o
);
  import cdt_pkg::*;
  logic tk, mv, stk;
  assign tk = instr.valid && instr_ready;
  assign mv = tk && instr.op_type == 6'h00;
  assign stk = mv && instr.rm == 3'h7;
  // ==========
  // properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  AST_ABS8_HI: assert property (mv && instr.mode == CDT_M_ABS8 && !instr.word |=>
    mem_o.req && mem_o.addr == {8'hFF, $past(instr.ext[7:0])}) else $error("abs8 address");
  AST_WORD_EVEN: assert property (mem_o.req && mem_o.word |-> !mem_o.addr[0])
    else $error("odd word address");
  AST_STK_BYTE: assert property (stk && !instr.word && instr.mode[2:1] == 2'h3 |=>
    status_o.illegal && !mem_o.req) else $error("stack byte form run");
  AST_PUSH: assert property (stk && instr.mode == CDT_M_PRE_DEC && instr.word
    && instr.to_mem |=> mem_o.req && mem_o.we && mem_o.word) else $error("push access");
  AST_POP: assert property (stk && instr.mode == CDT_M_POST_INC && instr.word
    && !instr.to_mem |=> mem_o.req && !mem_o.we && mem_o.word) else $error("pop access");
  AST_ACK: assert property (mem_o.req && mem_ack |=> !mem_o.req && status_o.done
    && instr_ready) else $error("access end");
  AST_BCC: assert property (tk && instr.op_type == 6'h29 && instr.cond < 4'h2 |=>
    status_o.branch_taken == ($past(instr.cond) == 4'h0)) else $error("branch");
  AST_FLAGS: assert property (flags_load && instr_ready && !instr.valid |=>
    flags_o == $past(flags_in)) else $error("flag load");
endmodule
`default_nettype wire

// ===== cdt_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdt_mem_model (
  input wire logic core_clk,
  input wire logic [3:0] lat,
  input wire cdt_pkg::cdt_mem_req_t mem_o,
  output var logic mem_ack = 1'b0,
  output var logic [15:0] mem_rdata = 16'h0
);
  import cdt_pkg::*;
  // ==========
  // words sit with the upper byte at the lower address
  logic [7:0] m [0:65535];
  logic [3:0] cnt = 4'h0;
  logic [15:0] a;
  assign a = mem_o.addr;
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    // idle data keeps toggling so a stale read never passes
    mem_rdata <= ~mem_rdata;
    cnt <= 4'h0;
    if (mem_o.req && !mem_ack && cnt < lat) begin
      cnt <= cnt + 4'h1;
    end else if (mem_o.req && !mem_ack) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_o.word ? {m[a], m[a + 16'h1]} : {8'h00, m[a]};
      if (mem_o.we) begin
        m[a] <= mem_o.word ? mem_o.wdata[15:8] : mem_o.wdata[7:0];
        if (mem_o.word) begin
          m[a + 16'h1] <= mem_o.wdata[7:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== cdt_data_transfer_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cdt_data_transfer_decode_tb;
  import cdt_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic flags_load = 1'b0;
  logic [2:0] rd_sel = 3'h0;
  logic [3:0] lat = 4'h0;
  cdt_flags_t flags_in = '0;
  cdt_instr_t instr = '0;
  logic mem_ack, instr_ready;
  logic [15:0] mem_rdata, rd_data, v;
  logic [15:0] g [0:7];
  cdt_flags_t flags_o;
  cdt_mem_req_t mem_o;
  cdt_status_t status_o;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] s = 32'h0000_0047;
  cdt_data_transfer_decode cdt_data_transfer_decode_i (.core_clk(core_clk), .rst_b(rst_b),
    .instr(instr), .instr_ready(instr_ready), .mem_o(mem_o), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .flags_load(flags_load), .flags_in(flags_in), .rd_sel(rd_sel),
    .rd_data(rd_data), .flags_o(flags_o), .status_o(status_o));
  cdt_mem_model cdt_mem_model_i (.core_clk(core_clk), .lat(lat), .mem_o(mem_o),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  function automatic logic [15:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s[15:0];
  endfunction
  function automatic logic tkn(input logic [3:0] c, input logic [3:0] f);
    case (c[3:1])
      3'h0: return !c[0];
      3'h1: return f[0] == c[0];
      3'h2: return f[2] == c[0];
      3'h3: return f[1] == c[0];
      3'h4: return f[3] == c[0];
      default: return 1'b0;
    endcase
  endfunction
  // type index map: 0 move, 1-14 arith, 15-18 logic, 19-26 shift, 27-40 bit, 41-45 branch,
  // 46-53 system, 54 block copy
  function automatic cdt_group_t grp(input int t);
    if (t == 0) return CDT_G_XFER;
    else if (t < 15) return CDT_G_ARITH;
    else if (t < 19) return CDT_G_LOGIC;
    else if (t < 27) return CDT_G_SHIFT;
    else if (t < 41) return CDT_G_BIT;
    else if (t < 46) return CDT_G_BRANCH;
    else if (t < 54) return CDT_G_SYS;
    else return CDT_G_BLOCK;
  endfunction
  task automatic conclude();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input cdt_instr_t i);
    int n;
    n = 0;
    @(negedge core_clk);
    instr = i;
    @(negedge core_clk);
    instr.valid = 1'b0;
    while (status_o.done !== 1'b1 && n < 30) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 30) chk(16'h0, 16'h1);
  endtask
  task automatic mv(input cdt_mode_t md, input logic w, input logic st, input logic [2:0] rn,
      input logic [2:0] rm, input logic [15:0] x);
    run('{1'b1, 6'h00, md, w, st, rn, 1'b1, rm, 1'b1, x, 4'h0});
  endtask
  task automatic rchk(input logic [2:0] r, input logic [15:0] e);
    rd_sel = r;
    @(negedge core_clk);
    chk(rd_data, e);
  endtask
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      conclude();
    end
  end
  // ==========
  // stimulus
  initial begin
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 16'h0 : rnd();
      g[k] = v;
      mv(CDT_M_IMM, 1'b1, 1'b0, 3'(k), 3'h0, v);
      chk({13'h0, flags_o.n, flags_o.z, flags_o.v}, {13'h0, v[15], v == 16'h0, 1'b0});
      rchk(3'(k), v);
    end
    mv(CDT_M_REG, 1'b1, 1'b0, 3'h2, 3'h1, 16'h0);
    rchk(3'h2, g[1]);
    mv(CDT_M_IMM, 1'b1, 1'b0, 3'h7, 3'h0, 16'h0200);
    lat = 4'h3;
    mv(CDT_M_PRE_DEC, 1'b1, 1'b1, 3'h1, 3'h7, 16'h0);
    rchk(3'h7, 16'h01FE);
    chk({cdt_mem_model_i.m[16'h01FE], cdt_mem_model_i.m[16'h01FF]}, g[1]);
    mv(CDT_M_POST_INC, 1'b1, 1'b0, 3'h3, 3'h7, 16'h0);
    rchk(3'h3, g[1]);
    rchk(3'h7, 16'h0200);
    v = rnd();
    mv(CDT_M_ABS8, 1'b0, 1'b1, 3'h1, 3'h0, v);
    chk({8'h0, cdt_mem_model_i.m[{8'hFF, v[7:0]}]}, {8'h0, g[1][7:0]});
    lat = 4'h0;
    mv(CDT_M_ABS16, 1'b1, 1'b1, 3'h2, 3'h0, 16'h1235);
    chk({cdt_mem_model_i.m[16'h1234], cdt_mem_model_i.m[16'h1235]}, g[1]);
    mv(CDT_M_IMM, 1'b1, 1'b0, 3'h5, 3'h0, 16'h1234);
    mv(CDT_M_POST_INC, 1'b0, 1'b0, 3'h6, 3'h5, 16'h0);
    rchk(3'h5, 16'h1235);
    rchk(3'h6, {g[6][15:8], g[1][15:8]});
    // r5 now 0x1235: displacement of -1 lands on the word stored at 0x1234
    mv(CDT_M_DISP16, 1'b1, 1'b0, 3'h4, 3'h5, 16'hFFFF);
    rchk(3'h4, g[1]);
    mv(CDT_M_IND, 1'b0, 1'b1, 3'h3, 3'h7, 16'h0);
    chk({8'h0, cdt_mem_model_i.m[16'h0200]}, {8'h0, g[1][7:0]});
    mv(CDT_M_ABS8, 1'b1, 1'b1, 3'h1, 3'h0, 16'h0010);
    chk({15'h0, status_o.illegal}, 16'h1);
    mv(CDT_M_REG, 1'b1, 1'b1, 3'h1, 3'h2, 16'h0);
    chk({15'h0, status_o.illegal}, 16'h1);
    // the undefined stack byte pre-decrement form goes out only here, to see it refused; the post-increment byte form is never sent
    mv(CDT_M_PRE_DEC, 1'b0, 1'b1, 3'h1, 3'h7, 16'h0);
    chk({15'h0, status_o.illegal}, 16'h1);
    rchk(3'h7, 16'h0200);
    for (int t = 0; t < 64; t++) begin
      run('{1'b1, 6'(t), CDT_M_REG, 1'b0, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 16'h0, 4'h0});
      chk({15'h0, status_o.illegal}, {15'h0, t > 54});
      if (t < 55) chk({13'h0, status_o.group}, {13'h0, grp(t)});
    end
    for (int k = 0; k < 33; k++) begin
      v = rnd();
      flags_in = cdt_flags_t'(v[3:0]);
      flags_load = 1'b1;
      @(negedge core_clk);
      flags_load = 1'b0;
      run('{1'b1, 6'h29, CDT_M_REG, 1'b0, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 16'h0, 4'(k % 11)});
      chk({15'h0, status_o.branch_taken}, {15'h0, tkn(4'(k % 11), v[3:0])});
      chk({12'h0, flags_o}, {12'h0, v[3:0]});
    end
    conclude();
  end
endmodule
bind cdt_data_transfer_decode cdt_dtd_assertions cdt_dtd_assertions_i (.core_clk(core_clk),
  .rst_b(rst_b), .instr(instr), .instr_ready(instr_ready), .mem_o(mem_o), .mem_ack(mem_ack),
  .flags_load(flags_load), .flags_in(flags_in), .flags_o(flags_o), .status_o(status_o));
`default_nettype wire
